//--- design/dct_regs.sv
/*
 * Serial-link register logic for the clear-code, trigger and status registers.
 * Assumes a 250 MHz clock well above the serial clock, a calibration engine that
 * answers recal_start with a one-cycle recal_done, and configuration bits from
 * elsewhere delivered as levels on the same clock.
 */
`timescale 1ns/1ps
module dct_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    input wire logic clear_in_n,
    input wire logic alarm_pin_enable,
    input wire logic serial_out_enable,
    input wire logic recal_done,
    output logic sdo,
    output logic sdo_oe,
    output logic alarm_n,
    output logic recal_start,
    output logic coef_apply,
    output logic soft_reset_cmd,
    output logic dac_clear_load,
    output logic [dct_pkg::CODE_W-1:0] dac_clear_code,
    output logic recal_done_flag
);
    import dct_pkg::*;

    // ==========================================================
    // Pin synchronisation and edge detection
    logic [3:0] pins_s;
    logic sclk_s, sync_s_n, sdin_s, clr_s_n;
    logic sclk_d, sync_d_n, clr_d_n;

    dct_sync #(
        .WIDTH(4),
        .INIT(4'hD)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .d({sclk, sync_n, sdin, clear_in_n}),
        .q(pins_s)
    );

    assign sclk_s = pins_s[3];
    assign sync_s_n = pins_s[2];
    assign sdin_s = pins_s[1];
    assign clr_s_n = pins_s[0];

    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_d <= 1'b1;
            sync_d_n <= 1'b1;
            clr_d_n <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            sync_d_n <= sync_s_n;
            clr_d_n <= clr_s_n;
        end
    end

    wire frame_on = ~sync_s_n;
    wire sclk_fall = sclk_d & ~sclk_s;
    wire sclk_rise = ~sclk_d & sclk_s;
    wire sync_rise = ~sync_d_n & sync_s_n;
    wire clr_fall = clr_d_n & ~clr_s_n;

    // ==========================================================
    // Frame capture
    logic [FRAME_BITS-1:0] rx_reg;
    logic [CNT_W-1:0] bit_cnt;
    logic frame_full;
    logic [FRAME_BITS-1:0] tx_reg;

    wire shift_in = frame_on & sclk_fall;
    wire [FRAME_BITS-1:0] frame_word = {rx_reg[FRAME_BITS-2:0], sdin_s};
    wire frame_done = shift_in & (bit_cnt == LAST_BIT_CNT) & ~frame_full;

    // A full frame ignores later clock edges, so the loaded answer is not shifted away.
    always_ff @(posedge clock) begin
        if (rst || !frame_on) begin
            bit_cnt <= '0;
            frame_full <= 1'b0;
        end else if (frame_done) begin
            frame_full <= 1'b1;
        end else if (shift_in && !frame_full) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_reg <= '0;
        end else if (shift_in) begin
            rx_reg <= frame_word;
        end
    end

    // ==========================================================
    // Decode
    // direction bit
    wire is_read = frame_word[DIR_BIT];
    // reserved bits are not checked; only the named bits act.
    wire [ADDR_W-1:0] frame_addr = frame_word[ADDR_HI:ADDR_LO];
    wire hit_code = frame_done & (frame_addr == ADDR_CLEAR_CODE);
    wire hit_trig = frame_done & (frame_addr == ADDR_TRIGGER);
    wire hit_stat = frame_done & (frame_addr == ADDR_STATUS);

    wire wr_code = hit_code & ~is_read;
    wire wr_trig = hit_trig & ~is_read;
    wire rd_stat = hit_stat & is_read;
    wire do_recal = wr_trig & frame_word[RECAL_BIT];
    wire do_soft_reset_cmd = wr_trig & frame_word[SOFT_RESET_CMD_BIT];
    wire do_soft_clear_cmd = wr_trig & frame_word[SOFT_CLEAR_CMD_BIT];

    // ==========================================================
    // Stored state
    logic [CODE_W-1:0] clear_code;
    logic flag;
    logic soft_clear_cmd_pending;

    always_ff @(posedge clock) begin
        if (rst || do_soft_reset_cmd) begin
            clear_code <= CLEAR_CODE_RST;
        end else if (wr_code) begin
            clear_code <= frame_word[CODE_HI:CODE_LO];
        end
    end

    // flag low while running; completion wins over a new start.
    always_ff @(posedge clock) begin
        if (rst || do_soft_reset_cmd) begin
            flag <= FLAG_RST;
        end else if (recal_done) begin
            flag <= 1'b1;
        end else if (do_recal) begin
            flag <= 1'b0;
        end
    end

    // clear waits for sync rise when the serial output is off.
    always_ff @(posedge clock) begin
        if (rst || do_soft_reset_cmd) begin
            soft_clear_cmd_pending <= 1'b0;
        end else if (do_soft_clear_cmd && !serial_out_enable) begin
            soft_clear_cmd_pending <= 1'b1;
        end else if (sync_rise) begin
            soft_clear_cmd_pending <= 1'b0;
        end
    end

    // ==========================================================
    // Readback
    logic [FRAME_BITS-1:0] read_data;

    always_comb begin
        read_data = '0;
        read_data[DIR_BIT] = 1'b1;
        read_data[ADDR_HI:ADDR_LO] = frame_addr;
        if (frame_addr == ADDR_CLEAR_CODE) begin
            read_data[CODE_HI:CODE_LO] = clear_code;
        end else if (frame_addr == ADDR_STATUS) begin
            read_data[FLAG_BIT] = flag;
        end
    end

    // A read answers in the next frame; any other frame is echoed for daisy chains.
    wire [FRAME_BITS-1:0] next_tx = is_read ? read_data : frame_word;

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_reg <= '0;
        end else if (frame_done) begin
            tx_reg <= next_tx;
        end else if (frame_on && sclk_rise && bit_cnt != '0 && !frame_full) begin
            tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
        end
    end

    assign sdo = tx_reg[FRAME_BITS-1];

    always_ff @(posedge clock) begin
        if (rst) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= serial_out_enable & frame_on;
        end
    end

    // ==========================================================
    // Commands and pins
    // software clear, immediate or deferred
    wire soft_clear_cmd_now = (do_soft_clear_cmd & serial_out_enable) | (soft_clear_cmd_pending & sync_rise);

    always_ff @(posedge clock) begin
        if (rst) begin
            recal_start <= 1'b0;
            coef_apply <= 1'b0;
            soft_reset_cmd <= 1'b0;
            dac_clear_load <= 1'b0;
        end else begin
            recal_start <= do_recal;
            coef_apply <= recal_done;
            soft_reset_cmd <= do_soft_reset_cmd;
            dac_clear_load <= clr_fall | soft_clear_cmd_now;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dac_clear_code <= CLEAR_CODE_RST;
            recal_done_flag <= FLAG_RST;
        end else begin
            dac_clear_code <= clear_code;
            recal_done_flag <= flag;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || do_soft_reset_cmd) begin
            alarm_n <= 1'b1;
        end else if (recal_done && alarm_pin_enable) begin
            alarm_n <= 1'b0;
        end else if (rd_stat) begin
            alarm_n <= 1'b1;
        end
    end
endmodule : dct_regs

//--- inc/dct_pkg.sv
/*
 * Constants for the clear-code, trigger and status register logic.
 * Assumes a 32-bit serial frame: direction bit, seven address bits, 24 data bits.
 */
package dct_pkg;
    // ==========================================================
    // Frame layout
    localparam int FRAME_BITS = 32;
    localparam int CNT_W = 6;
    localparam int DIR_BIT = 31;
    localparam int ADDR_HI = 30;
    localparam int ADDR_LO = 24;
    localparam int ADDR_W = 7;
    localparam logic [CNT_W-1:0] LAST_BIT_CNT = 6'h1F;
    // ==========================================================
    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_CLEAR_CODE = 7'h03;
    localparam logic [ADDR_W-1:0] ADDR_TRIGGER = 7'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h05;
    // ==========================================================
    // Fields
    localparam int CODE_W = 8;
    localparam int CODE_HI = 23;
    localparam int CODE_LO = 16;
    localparam int RECAL_BIT = 8;
    localparam int SOFT_RESET_CMD_BIT = 6;
    localparam int SOFT_CLEAR_CMD_BIT = 5;
    localparam int FLAG_BIT = 12;
    // ==========================================================
    // Reset values
    localparam logic [CODE_W-1:0] CLEAR_CODE_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
endpackage : dct_pkg

//--- design/dct_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes each bit is an independent level; no bus coherence is implied.
 */
`timescale 1ns/1ps
module dct_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : dct_sync

//--- verification/dct_properties.sv
/* Port checker for dct_regs; assumes the synchronous active-high rst on clock. */
`timescale 1ns/1ps
module dct_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    input wire logic clear_in_n,
    input wire logic alarm_pin_enable,
    input wire logic serial_out_enable,
    input wire logic recal_done,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic alarm_n,
    input wire logic recal_start,
    input wire logic coef_apply,
    input wire logic soft_reset_cmd,
    input wire logic dac_clear_load,
    input wire logic [dct_pkg::CODE_W-1:0] dac_clear_code,
    input wire logic recal_done_flag
);
    import dct_pkg::*;
    // ==========
    // Properties
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    AST_COEF: assert property (recal_done |=> coef_apply)
        else $error("coef_apply missing");
    AST_FLAG: assert property (recal_done ##1 !soft_reset_cmd |=> recal_done_flag)
        else $error("flag not set");
    AST_ALARM: assert property (recal_done && alarm_pin_enable ##1 !soft_reset_cmd |-> !alarm_n)
        else $error("alarm not low");
    AST_ALARM_CAUSE: assert property ($fell(alarm_n) |-> $past(recal_done) && $past(alarm_pin_enable))
        else $error("alarm without cause");
    AST_START: assert property (recal_start && !$past(recal_done) |=> !recal_done_flag)
        else $error("flag kept on start");
    AST_SOFT_RESET: assert property (soft_reset_cmd |-> alarm_n ##1 (dac_clear_code == CLEAR_CODE_RST && !recal_done_flag))
        else $error("soft reset incomplete");
    AST_CLEAR_PIN: assert property ($fell(clear_in_n) |-> ##[2:8] dac_clear_load)
        else $error("clear pin ignored");
    AST_OE: assert property (sync_n [*8] |-> !sdo_oe)
        else $error("sdo driven while idle");
    AST_OE_ON: assert property ((!sync_n && serial_out_enable) [*4] |=> sdo_oe)
        else $error("sdo not driven in frame");
    AST_OE_OFF: assert property (!serial_out_enable |=> !sdo_oe)
        else $error("sdo driven while disabled");
    cover property (recal_done && alarm_pin_enable);
    cover property (dac_clear_load && sync_n);
    cover property (soft_reset_cmd);
endmodule : dct_properties

//--- verification/dct_host.sv
/* Host model of the serial link; assumes sdin is taken on sclk falls. */
`timescale 1ns/1ps
module dct_host (
    output logic sclk,
    output logic sync_n,
    output logic sdin,
    input wire logic sdo
);
    localparam int HALF = 40;
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    // ==========
    // Frame transfer
    // direction first, msb first.
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        sync_n = 1'b0;
        #HALF;
        for (int i = 31; i >= 0; i--) begin
            sdin = w[i];
            #HALF;
            r[i] = sdo;
            sclk = 1'b0;
            #HALF;
            sclk = 1'b1;
        end
        #HALF;
        sync_n = 1'b1;
        // A released line shows no stale data.
        sdin = ~sdin;
        #(3*HALF);
    endtask : xfer
endmodule : dct_host

//--- verification/dct_regs_tb.sv
/* Testbench for dct_regs: host frames, calibration echo and pin stimulus.
   Assumes dct_pkg, dct_host and dct_properties are compiled first. */
`timescale 1ns/1ps
module dct_regs_tb;
    import dct_pkg::*;
    logic clock = 1'b0, rst = 1'b1, clear_in_n = 1'b1, alarm_pin_enable = 1'b0, serial_out_enable = 1'b1;
    logic recal_done = 1'b0, sclk, sync_n, sdin, sdo, sdo_oe, alarm_n, recal_start, coef_apply;
    logic soft_reset_cmd, dac_clear_load, recal_done_flag, ld_sync;
    logic [CODE_W-1:0] dac_clear_code;
    logic [31:0] r;
    int n_errors = 0, n_checks = 0, n_rs = 0, n_sr = 0, n_ld = 0, cyc = 0, cal = 0, k, seed = 31;
    always #2 clock = ~clock;
    dct_regs dut (.clock(clock), .rst(rst), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .clear_in_n(clear_in_n),
        .alarm_pin_enable(alarm_pin_enable), .serial_out_enable(serial_out_enable), .recal_done(recal_done),
        .sdo(sdo), .sdo_oe(sdo_oe), .alarm_n(alarm_n), .recal_start(recal_start), .coef_apply(coef_apply),
        .soft_reset_cmd(soft_reset_cmd), .dac_clear_load(dac_clear_load), .dac_clear_code(dac_clear_code),
        .recal_done_flag(recal_done_flag));
    dct_host host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo));
    // ==========
    // Monitors and calibration echo
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (recal_start) n_rs <= n_rs + 1;
        if (soft_reset_cmd) n_sr <= n_sr + 1;
        if (dac_clear_load) begin
            n_ld <= n_ld + 1;
            ld_sync <= sync_n;
        end
        if (cyc == 40000) begin
            n_errors++;
            end_sim();
        end
    end
    always @(negedge clock) begin
        recal_done <= (cal == 1);
        if (cal > 0) cal <= cal - 1;
        else if (recal_start) cal <= 2 + {$random(seed)} % 8;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] fr(input logic rd, input logic [6:0] a, input logic [23:0] d);
        return {rd, a, d};
    endfunction : fr
    task automatic xf(input logic [31:0] w);
        host.xfer(w, r);
        @(negedge clock);
    endtask : xf
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // ==========
    // Tests
    initial begin
        logic [7:0] c;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chk({alarm_n, recal_done_flag, sdo_oe, dac_clear_code}, 32'h400);
        xf(fr(1, ADDR_CLEAR_CODE, 0));
        xf(fr(1, ADDR_TRIGGER, 0));
        chk(r, fr(1, ADDR_CLEAR_CODE, 0));
        xf(fr(0, 7'h00, 0));
        chk(r, fr(1, ADDR_TRIGGER, 0));
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 8'hFF : 8'($random(seed));
            xf(fr(0, ADDR_CLEAR_CODE, {c, 16'h0000}));
            xf(fr(1, ADDR_CLEAR_CODE, 0));
            xf(fr(0, 7'h13, 24'hFFFFFF));
            chk(r, fr(1, ADDR_CLEAR_CODE, {c, 16'h0000}));
            chk(dac_clear_code, c);
        end
        k = n_ld;
        clear_in_n = 1'b0;
        repeat (10) @(negedge clock);
        clear_in_n = 1'b1;
        chk(n_ld - k, 1);
        for (int e = 1; e >= 0; e--) begin
            serial_out_enable = e[0];
            k = n_ld;
            xf(fr(0, ADDR_TRIGGER, 24'h000020));
            chk(n_ld - k, 1);
            chk(ld_sync, !e[0]);
        end
        serial_out_enable = 1'b1;
        $display("clear tests done");
        for (int e = 0; e < 2; e++) begin
            alarm_pin_enable = e[0];
            k = n_rs;
            xf(fr(0, ADDR_TRIGGER, 24'h000100));
            chk(n_rs - k, 1);
            chk({alarm_n, recal_done_flag}, {!e[0], 1'b1});
            xf(fr(1, ADDR_STATUS, 0));
            chk(alarm_n, 1);
            xf(fr(0, ADDR_STATUS, 0));
            chk(r, fr(1, ADDR_STATUS, 24'h001000));
            xf(fr(1, ADDR_STATUS, 0));
            xf(fr(0, 7'h00, 0));
            chk(r, fr(1, ADDR_STATUS, 24'h001000));
        end
        $display("recalibration tests done");
        k = n_sr;
        xf(fr(0, ADDR_TRIGGER, 24'h000040));
        chk(n_sr - k, 1);
        chk({alarm_n, recal_done_flag, dac_clear_code}, 32'h200);
        $display("soft reset test done");
        end_sim();
    end
endmodule : dct_regs_tb
bind dct_regs dct_properties u_props (.clock(clock), .rst(rst), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .clear_in_n(clear_in_n), .alarm_pin_enable(alarm_pin_enable), .serial_out_enable(serial_out_enable),
    .recal_done(recal_done), .sdo(sdo), .sdo_oe(sdo_oe), .alarm_n(alarm_n), .recal_start(recal_start),
    .coef_apply(coef_apply), .soft_reset_cmd(soft_reset_cmd), .dac_clear_load(dac_clear_load),
    .dac_clear_code(dac_clear_code), .recal_done_flag(recal_done_flag));
